/* File: verilog/fcl_defines.svh */
// Constants for the fractional FLL control block
`ifndef FCL_DEFINES_SVH
`define FCL_DEFINES_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define FCL_CLK_PERIOD_PS 25000
`define FCL_REF_TIMEOUT_NS 50000
`define FCL_REF_TIMEOUT_CYC 12'((`FCL_REF_TIMEOUT_NS * 1000) / `FCL_CLK_PERIOD_PS)
`define FCL_FREERUN_PERIOD 12'h100
`define FCL_CNT_SAT 12'hfff

// ****************************************************************
// Source select codes
// ****************************************************************
`define FCL_SRC_PIN_ONE 4'h0
`define FCL_SRC_PIN_TWO 4'h1
`define FCL_SRC_BUS 4'h2
`define FCL_SRC_OTHER 4'h3
`define FCL_SRC_BIT_BASE 4'h4
`define FCL_SRC_FRAME_BASE 4'h8
`define FCL_AUDIO_PORTS 4'h3

// ****************************************************************
// Bus gear and out divider
// ****************************************************************
`define FCL_GEAR_MAX 4'ha
`define FCL_OUTDIV_MIN 3'h2

`endif

/* File: verilog/fcl_pkg.sv */
// Types shared by the fractional FLL control block
`include "fcl_defines.svh"

package fcl_pkg;

  typedef enum logic [2:0] {
    FCL_OFF = 3'h1,
    FCL_RUN = 3'h2,
    FCL_FREE = 3'h4
  } fcl_mode_e;

  // Host-side configuration of one loop
  typedef struct packed {
    logic fllEnable;
    logic syncEnable;
    logic freerunHold;
    logic ctrlUpdate;
    logic [9:0] intMult;
    logic [15:0] fracNum;
    logic [15:0] fracDen;
    logic [3:0] refSourceSel;
    logic [3:0] syncSourceSel;
    logic [1:0] refPrediv;
    logic [1:0] syncPrediv;
    logic [3:0] ratioSel;
    logic [3:0] loopGain;
    logic [2:0] outDivider;
  } fcl_cfg_s;

  // Status and applied control value of one loop
  typedef struct packed {
    logic running;
    logic freeRunning;
    logic refPresent;
    logic syncActive;
    logic loopTick;
    logic [9:0] activeN;
    logic [15:0] activeTheta;
    logic [15:0] activeLambda;
    logic [3:0] activeGain;
    logic [3:0] activeRatio;
    logic [2:0] activeOutDiv;
  } fcl_status_s;

  typedef struct packed {
    fcl_mode_e mode;
    logic established;
    logic syncOn;
    logic [3:0] refSel;
    logic [3:0] syncSel;
    logic [1:0] refDiv;
    logic [1:0] syncDiv;
    logic [2:0] refDivCnt;
    logic [2:0] syncDivCnt;
    logic [3:0] ratioCnt;
    logic [2:0] outCnt;
    logic [11:0] sinceRef;
    logic [11:0] sinceSync;
    logic [11:0] periodCnt;
    logic [11:0] lastPeriod;
    fcl_status_s st;
  } fcl_loop_s;

  typedef struct packed {
    logic [8:0] pinPrev;
    logic [8:0] busDivCnt;
    logic busHit;
    fcl_loop_s [1:0] loop;
  } fcl_state_s;

endpackage

/* File: verilog/fcl_fll_control.sv */
// Dual fractional FLL control: reference selection, dividers, mode and control latching
`timescale 1ns/1ps
`include "fcl_defines.svh"

module fcl_fll_control (
  input wire logic ref_clk, // 40 MHz system clock
  input wire logic rst, // Synchronous reset, active high
  input wire fcl_pkg::fcl_cfg_s [1:0] cfg, // Per-loop configuration fields
  input wire logic masterClockPinOne, // Master clock pin one level
  input wire logic masterClockPinTwo, // Master clock pin two level
  input wire logic serialBusClockIn, // Serial bus clock level
  input wire logic [3:0] busClockGear, // Current serial bus clock gear
  input wire logic [2:0] audioPortBitClock, // Audio port bit clocks
  input wire logic [2:0] audioPortFrameClock, // Audio port frame clocks
  output fcl_pkg::fcl_status_s [1:0] loopStatus // Per-loop status and control word
);
  import fcl_pkg::*;

  fcl_state_s cur;
  fcl_state_s next_cur;

  // Predivider terminal count for ratio 1, 2, 4 or 8
  function automatic logic [2:0] preMax(input logic [1:0] code);
    preMax = 3'((4'h1 << code) - 4'h1);
  endfunction

  // Adaptive bus divider: each gear step down from 10 to 1 doubles the division; gear 0 acts as gear 1
  function automatic logic [8:0] gearMax(input logic [3:0] gear);
    logic [3:0] g;
    g = (gear == 4'h0) ? 4'h1 : ((gear > `FCL_GEAR_MAX) ? `FCL_GEAR_MAX : gear);
    gearMax = 9'((10'h1 << (`FCL_GEAR_MAX - g)) - 10'h1);
  endfunction

  // Picks one rising-edge pulse by source code
  function automatic logic srcPulse(input logic [3:0] sel, input logic [8:0] rise,
                                    input logic busEvt, input logic otherTick);
    srcPulse = 1'b0;
    if (sel == `FCL_SRC_PIN_ONE) begin
      srcPulse = rise[0];
    end else if (sel == `FCL_SRC_PIN_TWO) begin
      srcPulse = rise[1];
    end else if (sel == `FCL_SRC_BUS) begin
      srcPulse = busEvt;
    end else if (sel == `FCL_SRC_OTHER) begin
      srcPulse = otherTick;
    end else if (sel >= `FCL_SRC_BIT_BASE && sel < `FCL_SRC_BIT_BASE + `FCL_AUDIO_PORTS) begin
      srcPulse = rise[3 + 2'(sel - `FCL_SRC_BIT_BASE)];
    end else if (sel >= `FCL_SRC_FRAME_BASE && sel < `FCL_SRC_FRAME_BASE + `FCL_AUDIO_PORTS) begin
      srcPulse = rise[6 + 2'(sel - `FCL_SRC_FRAME_BASE)];
    end
  endfunction

  // Saturating cycle counter step
  function automatic logic [11:0] satInc(input logic [11:0] v);
    satInc = (v == `FCL_CNT_SAT) ? v : 12'(v + 12'h1);
  endfunction

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  logic [8:0] pins;
  logic [8:0] rise;
  fcl_loop_s l;
  fcl_loop_s n;
  logic otherTick;
  logic refPulse;
  logic refHit;
  logic syncPulse;
  logic syncHit;
  logic refPresent;
  logic syncPresent;
  logic liveEvt;
  logic ratioHit;
  logic loopEvt;
  logic [2:0] outMax;

  // Both loops share the edge detectors and bus divider, then step independently
  always_comb begin
    next_cur = cur;
    l = cur.loop[0];
    n = l;
    otherTick = 1'b0;
    refPulse = 1'b0;
    refHit = 1'b0;
    syncPulse = 1'b0;
    syncHit = 1'b0;
    refPresent = 1'b0;
    syncPresent = 1'b0;
    liveEvt = 1'b0;
    ratioHit = 1'b0;
    loopEvt = 1'b0;
    outMax = `FCL_OUTDIV_MIN;
    pins = {audioPortFrameClock, audioPortBitClock, serialBusClockIn, masterClockPinTwo, masterClockPinOne};
    rise = pins & ~cur.pinPrev;
    next_cur.pinPrev = pins;
    // Bus edges thinned so the loop sees a constant rate across gears
    next_cur.busHit = 1'b0;
    if (rise[2]) begin
      if (cur.busDivCnt >= gearMax(busClockGear)) begin
        next_cur.busDivCnt = 9'h0;
        next_cur.busHit = 1'b1;
      end else begin
        next_cur.busDivCnt = 9'(cur.busDivCnt + 9'h1);
      end
    end
    for (int i = 0; i < 2; i++) begin
      l = cur.loop[i];
      n = l;
      n.st.loopTick = 1'b0;
      otherTick = (i == 0) ? cur.loop[1].st.loopTick : cur.loop[0].st.loopTick;
      // Reference and synchroniser predividers
      refPulse = srcPulse(l.refSel, rise, cur.busHit, otherTick);
      syncPulse = srcPulse(l.syncSel, rise, cur.busHit, otherTick);
      refHit = refPulse && (l.refDivCnt == preMax(l.refDiv));
      syncHit = syncPulse && (l.syncDivCnt == preMax(l.syncDiv));
      if (refPulse) begin
        n.refDivCnt = refHit ? 3'h0 : 3'(l.refDivCnt + 3'h1);
      end
      if (syncPulse) begin
        n.syncDivCnt = syncHit ? 3'h0 : 3'(l.syncDivCnt + 3'h1);
      end
      n.sinceRef = refHit ? 12'h0 : satInc(l.sinceRef);
      n.sinceSync = syncHit ? 12'h0 : satInc(l.sinceSync);
      refPresent = l.sinceRef < `FCL_REF_TIMEOUT_CYC;
      syncPresent = l.sinceSync < `FCL_REF_TIMEOUT_CYC;
      n.st.refPresent = refPresent;
      // Enabled synchroniser replaces the reference for the ratio divider whenever its clock is alive; presence and mode still follow the main reference
      n.st.syncActive = l.syncOn && syncPresent && (l.mode != FCL_OFF);
      liveEvt = (l.syncOn && syncPresent) ? syncHit : refHit;
      // Ratio divider on the live reference, only while locked to it
      ratioHit = 1'b0;
      if (l.mode == FCL_RUN && liveEvt) begin
        ratioHit = (l.ratioCnt >= l.st.activeRatio);
        n.ratioCnt = ratioHit ? 4'h0 : 4'(l.ratioCnt + 4'h1);
      end
      // Period memory lets free-running continue at the last rate
      n.periodCnt = satInc(l.periodCnt);
      loopEvt = 1'b0;
      if (l.mode == FCL_RUN && ratioHit) begin
        loopEvt = 1'b1;
        n.periodCnt = 12'h0;
        if (l.established) begin
          n.lastPeriod = satInc(l.periodCnt);
        end
        n.established = 1'b1;
      end else if (l.mode == FCL_FREE && satInc(l.periodCnt) >= l.lastPeriod) begin
        loopEvt = 1'b1;
        n.periodCnt = 12'h0;
      end
      // Output divider; codes below two fall back to divide by two
      outMax = (l.st.activeOutDiv < `FCL_OUTDIV_MIN) ? `FCL_OUTDIV_MIN : l.st.activeOutDiv;
      if (loopEvt) begin
        if (3'(l.outCnt + 3'h1) >= outMax) begin
          n.outCnt = 3'h0;
          n.st.loopTick = 1'b1;
        end else begin
          n.outCnt = 3'(l.outCnt + 3'h1);
        end
      end
      // Mode sequencing
      case (l.mode)
        FCL_OFF: begin
          if (cfg[i].fllEnable) begin
            n.established = 1'b0;
            n.periodCnt = 12'h0;
            n.lastPeriod = `FCL_FREERUN_PERIOD;
            // Hold bit lets the loop start with no reference at all
            n.mode = (!refPresent && cfg[i].freerunHold) ? FCL_FREE : FCL_RUN;
          end
        end
        FCL_RUN: begin
          if (!cfg[i].fllEnable) begin
            n.mode = FCL_OFF;
          end else if (cfg[i].freerunHold) begin
            n.mode = FCL_FREE;
          end else if (!refPresent && l.established) begin
            n.mode = FCL_FREE;
          end
        end
        FCL_FREE: begin
          if (!cfg[i].fllEnable) begin
            n.mode = FCL_OFF;
          end else if (!cfg[i].freerunHold && refPresent) begin
            n.mode = FCL_RUN;
          end
        end
        default: begin
          n.mode = FCL_OFF;
        end
      endcase
      n.st.running = (n.mode != FCL_OFF);
      n.st.freeRunning = (n.mode == FCL_FREE);
      // Control latching: disabled loops follow the fields directly
      if (!cfg[i].fllEnable) begin
        n.st.activeN = cfg[i].intMult;
        n.st.activeTheta = cfg[i].fracNum;
        n.st.activeLambda = cfg[i].fracDen;
        n.st.activeGain = cfg[i].loopGain;
        n.st.activeRatio = cfg[i].ratioSel;
        n.st.activeOutDiv = cfg[i].outDivider;
        n.syncOn = cfg[i].syncEnable;
        n.refSel = cfg[i].refSourceSel;
        n.syncSel = cfg[i].syncSourceSel;
        n.refDiv = cfg[i].refPrediv;
        n.syncDiv = cfg[i].syncPrediv;
      end else if (cfg[i].ctrlUpdate && !cfg[i].freerunHold) begin
        // Both fields move together; the hold bit freezes the value
        n.st.activeN = cfg[i].intMult;
        n.st.activeTheta = cfg[i].fracNum;
      end
      next_cur.loop[i] = n;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // All state lives in one register; reset parks both loops off
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cur <= '0;
      for (int i = 0; i < 2; i++) begin
        cur.loop[i].mode <= FCL_OFF;
        cur.loop[i].sinceRef <= `FCL_CNT_SAT;
        cur.loop[i].sinceSync <= `FCL_CNT_SAT;
        cur.loop[i].lastPeriod <= `FCL_FREERUN_PERIOD;
      end
    end else begin
      cur <= next_cur;
    end
  end

  // Status straight from the state register
  assign loopStatus = {cur.loop[1].st, cur.loop[0].st};

endmodule

/* File: tb/fcl_fll_checker.sv */
// Concurrent checks on loop one of the dual FLL control block, plus a reset check on both loops
`timescale 1ns/1ps
module fcl_fll_checker (
  input wire logic ref_clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire fcl_pkg::fcl_cfg_s [1:0] cfg, // Loop configuration
  input wire logic masterClockPinOne, // Reference pin one
  input wire fcl_pkg::fcl_status_s [1:0] loopStatus // Loop status
);
  import fcl_pkg::*;
  // ****************************************
  // Loop one properties, plus a reset check on both loops
  // ****************************************
  fcl_cfg_s c;
  fcl_status_s s;
  // Loop two is left to the bench comparisons, apart from the reset check on the whole status
  assign c = cfg[0];
  assign s = loopStatus[0];
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_reset; disable iff (1'b0) rst |=> loopStatus == '0; endproperty
  property p_enable; $rose(c.fllEnable) |-> ##[1:3] (s.running || s.freeRunning); endproperty
  property p_off; $fell(c.fllEnable) |-> ##[1:3] !(s.running || s.freeRunning); endproperty
  property p_hold; (c.fllEnable && c.freerunHold)[*4] |-> $stable(s.activeN) && $stable(s.activeTheta); endproperty
  property p_nostrobe; (c.fllEnable && !c.ctrlUpdate)[*4] |-> $stable(s.activeN) && $stable(s.activeTheta);
  endproperty
  // Fields must stay put after the strobe, otherwise the expected value is unknown
  property p_update; (c.fllEnable && $past(c.fllEnable) && c.ctrlUpdate && !c.freerunHold)
    ##1 ($stable(c.intMult) && $stable(c.fracNum))[*2] |-> s.activeN == c.intMult && s.activeTheta == c.fracNum;
  endproperty
  property p_follow; (!c.fllEnable && $stable(c.intMult) && $stable(c.fracNum))[*3]
    |-> s.activeN == c.intMult && s.activeTheta == c.fracNum; endproperty
  property p_frozen; c.fllEnable[*4] |-> $stable(s.activeLambda) && $stable(s.activeGain)
    && $stable(s.activeRatio) && $stable(s.activeOutDiv); endproperty
  property p_refseen; (c.fllEnable && c.refSourceSel == 4'h0 && c.refPrediv == 2'h0)[*4]
    ##0 $rose(masterClockPinOne) |-> ##[1:2] s.refPresent; endproperty
  a_reset: assert property (p_reset) else $error("status not cleared by reset");
  a_enable: assert property (p_enable) else $error("loop did not start");
  a_off: assert property (p_off) else $error("loop did not stop");
  a_hold: assert property (p_hold) else $error("control word moved under hold");
  a_nostrobe: assert property (p_nostrobe) else $error("control word moved without strobe");
  a_update: assert property (p_update) else $error("strobe did not apply both fields");
  a_follow: assert property (p_follow) else $error("disabled loop ignores fields");
  a_frozen: assert property (p_frozen) else $error("ratio fields moved while enabled");
  a_refseen: assert property (p_refseen) else $error("reference edge not seen");
  c_tick: cover property (s.loopTick && s.running);
  c_free: cover property (s.freeRunning && !s.refPresent);
  c_strobe: cover property (c.ctrlUpdate && c.fllEnable);
endmodule

bind fcl_fll_control fcl_fll_checker chk (.ref_clk(ref_clk), .rst(rst), .cfg(cfg),
  .masterClockPinOne(masterClockPinOne), .loopStatus(loopStatus));

/* File: tb/fcl_host_model.sv */
// Host model that sequences loop one configuration like driver software
`timescale 1ns/1ps
module fcl_host_model (
  input wire logic ref_clk, // System clock
  output fcl_pkg::fcl_cfg_s cfgOut // Loop one fields
);
  import fcl_pkg::*;
  // ****************************************
  // Host sequences, all driven at falling edges
  // ****************************************
  initial cfgOut = '0;
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Fields first, enable last; one reference always sits on the main path
  task automatic start(input logic [3:0] src, input logic [1:0] div, input logic [3:0] r, input logic hold);
    cfgOut.syncEnable = 1'b0;
    cfgOut.refSourceSel = src;
    cfgOut.refPrediv = div;
    cfgOut.ratioSel = r;
    cfgOut.outDivider = 3'h2;
    cfgOut.freerunHold = hold;
    tick(2);
    cfgOut.fllEnable = 1'b1;
  endtask
  // Hold first so the loop passes through free-running before it is switched off
  task automatic stop();
    cfgOut.freerunHold = 1'b1;
    tick(1);
    cfgOut.fllEnable = 1'b0;
    tick(1);
    cfgOut.freerunHold = 1'b0;
  endtask
  // Live retune: hold, let 32 us pass, write, release; strobe comes later
  task automatic retune(input logic [9:0] n, input logic [15:0] t);
    cfgOut.freerunHold = 1'b1;
    tick(1280);
    cfgOut.intMult = n;
    cfgOut.fracNum = t;
    tick(2);
    cfgOut.freerunHold = 1'b0;
    tick(2);
  endtask
  task automatic strobe();
    cfgOut.ctrlUpdate = 1'b1;
    tick(1);
    cfgOut.ctrlUpdate = 1'b0;
  endtask
endmodule

/* File: tb/fcl_fll_control_bench.sv */
// Self-checking bench for the dual FLL control block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; \
  if ((got) !== (ex)) begin n_fail++; $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module fcl_fll_control_bench;
  import fcl_pkg::*;
  // ****************************************
  // Stimulus and checks
  // ****************************************
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic refWave = 1'b0;
  logic runRef = 1'b0;
  logic [1:0] phase = 2'h0;
  logic [63:0] rnd;
  fcl_cfg_s hostCfg;
  fcl_cfg_s benchCfg = '0;
  fcl_status_s [1:0] loopStatus;
  int n_fail = 0;
  int checked = 0;
  int seed = 19;
  int ticks;
  logic [3:0] srcs [9] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'ha};
  always #12.5 ref_clk = ~ref_clk;
  // One shared wave feeds every clock pin so each select in srcs gives the same rate
  always @(negedge ref_clk) begin
    if (runRef) begin
      phase = phase + 2'h1;
      refWave = phase[1];
    end
  end
  fcl_fll_control dut (.ref_clk(ref_clk), .rst(rst), .cfg({benchCfg, hostCfg}), .masterClockPinOne(refWave),
    .masterClockPinTwo(refWave), .serialBusClockIn(refWave), .busClockGear(4'ha),
    .audioPortBitClock({3{refWave}}), .audioPortFrameClock({3{refWave}}), .loopStatus(loopStatus));
  fcl_host_model host (.ref_clk(ref_clk), .cfgOut(hostCfg));
  // Reference edge every 4 cycles, then prediv, ratio and a divide by two
  function automatic int expTicks(input int p, input int r);
    return 384 / (8 * (1 << p) * (r + 1));
  endfunction
  function automatic logic [2:0] expDiv(input logic [2:0] code);
    return 3'h2 + 3'(code % 3'h6);
  endfunction
  task automatic cnt(input int n);
    ticks = 0;
    repeat (n) begin
      @(negedge ref_clk);
      ticks += int'(loopStatus[0].loopTick);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic end_of_test();
    $display("checks %0d fails %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Watchdog turns a hang into a counted mismatch
  initial begin
    wait_n(40000);
    n_fail++;
    end_of_test();
  end
  initial begin
    wait_n(5);
    rst = 1'b0;
    wait_n(1);
    `CHK("reset", '0, loopStatus)
    for (int i = 0; i < 16; i++) begin
      rnd = {$random(seed), $random(seed)};
      {benchCfg.intMult, benchCfg.fracNum, benchCfg.fracDen, benchCfg.loopGain, benchCfg.ratioSel} = rnd[49:0];
      benchCfg.outDivider = expDiv(rnd[52:50]);
      wait_n(2);
      `CHK("nk", {benchCfg.intMult, benchCfg.fracNum}, {loopStatus[1].activeN, loopStatus[1].activeTheta})
      `CHK("ratio", {benchCfg.fracDen, benchCfg.loopGain, benchCfg.ratioSel, benchCfg.outDivider}, {loopStatus[1]
        .activeLambda, loopStatus[1].activeGain, loopStatus[1].activeRatio, loopStatus[1].activeOutDiv})
    end
    $display("test fields done");
    runRef = 1'b1;
    foreach (srcs[i]) begin
      host.start(srcs[i], 2'(i % 4), 4'(i % 3), 1'b0);
      wait_n(200);
      `CHK("running", 1'b1, loopStatus[0].running)
      cnt(384);
      `CHK("ticks", expTicks(i % 4, i % 3), ticks)
      host.stop();
      wait_n(2);
      `CHK("stopped", 1'b0, loopStatus[0].running)
    end
    $display("test sources done");
    // Second loop with two references: a live synchroniser takes over
    benchCfg = '0;
    benchCfg.syncEnable = 1'b1;
    benchCfg.refSourceSel = 4'h0;
    benchCfg.syncSourceSel = 4'h1;
    benchCfg.outDivider = 3'h2;
    wait_n(2);
    benchCfg.fllEnable = 1'b1;
    wait_n(200);
    `CHK("sync running", 1'b1, loopStatus[1].running)
    `CHK("sync active", 1'b1, loopStatus[1].syncActive)
    `CHK("loop one idle", 1'b0, loopStatus[0].running)
    // Synchroniser source that selects nothing: main path stays the reference
    benchCfg.fllEnable = 1'b0;
    wait_n(2);
    benchCfg.syncSourceSel = 4'hf;
    wait_n(2);
    benchCfg.fllEnable = 1'b1;
    wait_n(2100);
    `CHK("sync lost", 1'b0, loopStatus[1].syncActive)
    `CHK("main kept", 1'b1, loopStatus[1].refPresent)
    `CHK("still run", 1'b0, loopStatus[1].freeRunning)
    benchCfg.fllEnable = 1'b0;
    wait_n(2);
    `CHK("sync off", 1'b0, loopStatus[1].syncActive)
    $display("test synchroniser done");
    host.start(4'h0, 2'h0, 4'h0, 1'b0);
    wait_n(200);
    host.retune(10'h155, 16'h1234);
    `CHK("held n", 10'h000, loopStatus[0].activeN)
    host.strobe();
    wait_n(3);
    `CHK("new nk", {10'h155, 16'h1234}, {loopStatus[0].activeN, loopStatus[0].activeTheta})
    runRef = 1'b0;
    wait_n(2100);
    `CHK("refgone", 1'b0, loopStatus[0].refPresent)
    `CHK("freerun", 1'b1, loopStatus[0].freeRunning)
    cnt(384);
    `CHK("frticks", 1'b1, ticks > 0)
    host.stop();
    wait_n(2);
    `CHK("frstop", 1'b0, loopStatus[0].freeRunning)
    $display("test freerun done");
    host.start(4'h0, 2'h0, 4'h0, 1'b1);
    wait_n(10);
    `CHK("coldfree", 1'b1, loopStatus[0].freeRunning)
    cnt(1024);
    `CHK("coldticks", 1'b1, ticks > 0)
    host.stop();
    $display("test cold start done");
    end_of_test();
  end
endmodule
